// ==== hw/swt_pkg.sv ====
/*
 * Shared constants and types for the sweep acquisition timing block:
 * register indices, control bit positions, event record layout and the
 * state types. Assumes one CLK cycle is one sweep timer unit.
 */
`default_nettype none
package swt_pkg;
	// ------------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------------
	localparam int TW = 48;        // Delay, range, hold-off, sweep count
	localparam int EW = 53;        // Event time stamp width
	localparam int NCH = 8;        // Seven stop inputs plus start
	localparam int FW = 5;         // Fine bits, 32 bins per timer unit
	localparam int TAGW = 16;      // Tag inputs
	localparam int AW = 4;         // Register index width
	localparam int DW = 32;        // Register data width
	localparam int RW = 64;        // Event record width
	localparam int MW = 6;         // Monitor select width
	localparam logic [2:0] START_CH = 3'h7;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int PERIOD_NS = 50;
	localparam int DEAD_NS = 46;
	localparam int DEAD_RAW = (DEAD_NS + PERIOD_NS - 1) / PERIOD_NS;
	localparam logic [TW-1:0] DEAD_CYC = TW'((DEAD_RAW < 1) ? 1 : DEAD_RAW);

	// ------------------------------------------------------------------
	// Register indices
	// ------------------------------------------------------------------
	localparam logic [AW-1:0] A_CTRL = 4'h0;
	localparam logic [AW-1:0] A_CHEN = 4'h1;
	localparam logic [AW-1:0] A_EDGE = 4'h2;
	localparam logic [AW-1:0] A_DLY_LO = 4'h3;
	localparam logic [AW-1:0] A_DLY_HI = 4'h4;
	localparam logic [AW-1:0] A_RNG_LO = 4'h5;
	localparam logic [AW-1:0] A_RNG_HI = 4'h6;
	localparam logic [AW-1:0] A_HLD_LO = 4'h7;
	localparam logic [AW-1:0] A_HLD_HI = 4'h8;
	localparam logic [AW-1:0] A_PRE_LO = 4'h9;
	localparam logic [AW-1:0] A_PRE_HI = 4'ha;
	localparam logic [AW-1:0] A_SWP_LO = 4'hb;
	localparam logic [AW-1:0] A_SWP_HI = 4'hc;
	localparam logic [AW-1:0] A_STAT = 4'hd;
	localparam logic [AW-1:0] A_MON = 4'he;

	// Control bits
	localparam int C_ARM = 0;
	localparam int C_ENDLESS = 1;
	localparam int C_PRESET = 2;
	localparam int C_START_CH = 3;
	localparam int C_TAG = 4;
	localparam int C_SWSTART = 5;  // Write-only pulse
	localparam int C_SWCLR = 6;    // Write-only pulse
	localparam int CTRL_W = 5;
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
	localparam logic [NCH-1:0] CHEN_RST = 8'h7f;
	localparam logic [2*NCH-1:0] EDGE_RST = 16'h5555; // Rising only
	localparam int HI_W = TW - DW;

	// Status bits
	localparam int S_LOST = 8;     // Sticky, write one to clear

	// Event record layout
	localparam int R_TIME = 0;
	localparam int R_EDGE = 53;
	localparam int R_CHAN = 55;
	localparam int R_TAG = 37;

	// Monitor selects: top timer bit, then those above the timer bits
	localparam logic [MW-1:0] M_TIME_TOP = 6'h1d;
	localparam logic [MW-1:0] M_SWP_BASE = 6'h20;
	localparam logic [MW-1:0] M_SWP_TOP = 6'h2b;
	localparam logic [MW-1:0] M_ARMED = 6'h30;
	localparam logic [MW-1:0] M_SWEEP = 6'h31;
	localparam logic [MW-1:0] M_WINDOW = 6'h32;
	localparam logic [MW-1:0] M_HOLD = 6'h33;
	localparam logic [MW-1:0] M_DEAD = 6'h34;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_ARMED = 3'b001,
		S_RUN = 3'b010,
		S_DEAD = 3'b011,
		S_HOLD = 3'b100
	} swt_state_e;

	typedef struct packed {
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
		logic wr;
		logic rd;
	} swt_bus_s;

	typedef struct packed {
		// Input synchronisers
		logic [NCH-1:0] pin1, pin2, pin3;
		logic [NCH*FW-1:0] fin1, fin2;
		logic [TAGW-1:0] tag1, tag2, tag_smp;
		// Configuration
		logic [CTRL_W-1:0] ctrl;
		logic [NCH-1:0] chen;
		logic [2*NCH-1:0] edge_cfg;
		logic [TW-1:0] dly, rng, hld, pre;
		logic [MW-1:0] mon_sel;
		// Sweep machine
		swt_state_e st;
		logic [TW-1:0] timer, cnt, sweeps;
		logic lost;
		// Registered outputs
		logic evt_valid;
		logic [RW-1:0] evt_data;
		logic [DW-1:0] rdata;
		logic mon, tag_clk, armed, sweep_on;
	} swt_state_s;
endpackage
`default_nettype wire

// ==== hw/swt_sweep_timing.sv ====
/*
 * Sweep timing controller for a multi-channel stop-event digitizer:
 * arming, start detection, delay and range window, dead time, hold-off,
 * sweep counter with preset, endless mode, tag sampling and event records.
 * Assumes detector levels, fine codes and tags arrive asynchronously and
 * that one CLK cycle equals one sweep timer unit.
 */
// Decided for this implementation: strobed register access and the register addresses.
// Notes on behaviour
// - Armed: START edge begins sweep and acquisition
// - Per-channel rising/falling/both edges, edge marked
// - Acquisition delay, even units, suppresses early stops
// - Sweep ends when time range elapses
// - Fixed dead time after sweep end
// - Hold-off blocks new start after sweep
// - Delay, range, hold-off are 48-bit counts
// - Events outside window are discarded
// - Sweep counter increments at sweep start
// - Preset reached blocks further sweep starts
// - Low 12 sweep counter bits on monitor
// - Endless mode: one start, absolute times
// - Time stamps 53 bits, fine bins
// - Thirty timer bits selectable on monitor
// - START optionally sampled as eighth channel
// - Record holds channel and common-base time
// - Sixteen tags sampled, stored with events
// - Tag clock driven as strobe
// - Tags overwrite upper time stamp bits when enabled
`default_nettype none
module swt_sweep_timing
	import swt_pkg::*;
(
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic CE,
	input wire logic [AW-1:0] ADDR,
	input wire logic [DW-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [DW-1:0] RDATA,
	input wire logic START_IN,
	input wire logic [NCH-2:0] STOP_IN,
	input wire logic [NCH*FW-1:0] FINE_IN,
	input wire logic [TAGW-1:0] TAG_IN,
	output logic TAG_CLK,
	output logic EVT_VALID,
	output logic [RW-1:0] EVT_DATA,
	output logic MON,
	output logic ARMED,
	output logic SWEEP_ON
);
	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Lowest set channel wins when several fire together
	function automatic logic [2:0] first_ch(input logic [NCH-1:0] v);
		logic [2:0] r;
		r = '0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	swt_state_s q, d;        // Whole state and its next value
	swt_bus_s bus;           // Register port bundle
	logic [NCH-1:0] rise, fall, hit;
	logic [NCH-1:0] ch_ok;
	logic [TW-1:0] dly_eff;
	logic in_win, start_ev, blocked, sw_start;
	logic [2:0] ch;
	logic [RW-1:0] rec;

	assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

	// ------------------------------------------------------------------
	// Edge detection and window
	// ------------------------------------------------------------------
	always_comb begin
		rise = q.pin2 & ~q.pin3;
		fall = ~q.pin2 & q.pin3;
		ch_ok = q.chen;
		ch_ok[START_CH] = q.chen[START_CH] & q.ctrl[C_START_CH];
		for (int i = 0; i < NCH; i++) begin
			// Edge kinds selected per channel
			hit[i] = ch_ok[i] & ((rise[i] & q.edge_cfg[2*i])
				| (fall[i] & q.edge_cfg[2*i+1]));
		end
		// START trigger uses the start channel's edge selection
		start_ev = (rise[START_CH] & q.edge_cfg[2*START_CH])
			| (fall[START_CH] & q.edge_cfg[2*START_CH+1]);
		dly_eff = {q.dly[TW-1:1], 1'b0};
		// Acquire from delay on, and below range unless endless
		in_win = (q.st == S_RUN) && (q.timer >= dly_eff)
			&& (q.ctrl[C_ENDLESS] || (q.timer < q.rng));
		blocked = q.ctrl[C_PRESET] && (q.sweeps >= q.pre);
		sw_start = bus.wr && (bus.addr == A_CTRL) && bus.wdata[C_SWSTART];
		ch = first_ch(hit);
	end

	// ------------------------------------------------------------------
	// Event record build
	// ------------------------------------------------------------------
	always_comb begin
		rec = '0;
		// Coarse timer with fine bin appended
		rec[R_TIME +: EW] = {q.timer, q.fin2[ch*FW +: FW]};
		rec[R_EDGE +: 2] = {fall[ch], rise[ch]};
		rec[R_CHAN +: 3] = ch;
		if (q.ctrl[C_TAG]) begin
			rec[R_TAG +: TAGW] = q.tag_smp;
		end
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		d = q;
		// Two-stage synchronisers, third stage for edge history
		d.pin1 = {START_IN, STOP_IN};
		d.pin2 = q.pin1;
		d.pin3 = q.pin2;
		d.fin1 = FINE_IN;
		d.fin2 = q.fin1;
		d.tag1 = TAG_IN;
		d.tag2 = q.tag1;
		// Tag strobe toggles every cycle, tags caught on its rise
		d.tag_clk = ~q.tag_clk;
		if (!q.tag_clk) begin
			d.tag_smp = q.tag2;
		end

		// Register writes
		if (bus.wr) begin
			case (bus.addr)
				A_CTRL: d.ctrl = bus.wdata[CTRL_W-1:0];
				A_CHEN: d.chen = bus.wdata[NCH-1:0];
				A_EDGE: d.edge_cfg = bus.wdata[2*NCH-1:0];
				A_DLY_LO: d.dly[DW-1:0] = bus.wdata;
				A_DLY_HI: d.dly[TW-1:DW] = bus.wdata[HI_W-1:0];
				A_RNG_LO: d.rng[DW-1:0] = bus.wdata;
				A_RNG_HI: d.rng[TW-1:DW] = bus.wdata[HI_W-1:0];
				A_HLD_LO: d.hld[DW-1:0] = bus.wdata;
				A_HLD_HI: d.hld[TW-1:DW] = bus.wdata[HI_W-1:0];
				A_PRE_LO: d.pre[DW-1:0] = bus.wdata;
				A_PRE_HI: d.pre[TW-1:DW] = bus.wdata[HI_W-1:0];
				A_MON: d.mon_sel = bus.wdata[MW-1:0];
				default: d.ctrl = q.ctrl; // Others ignored
			endcase
			if (bus.addr == A_CTRL && bus.wdata[C_SWCLR]) begin
				d.sweeps = '0;
			end
			if (bus.addr == A_STAT && bus.wdata[S_LOST]) begin
				d.lost = 1'b0;
			end
		end

		// Register reads, data stands one cycle only
		d.rdata = '0;
		if (bus.rd) begin
			case (bus.addr)
				A_CTRL: d.rdata = DW'(q.ctrl);
				A_CHEN: d.rdata = DW'(q.chen);
				A_EDGE: d.rdata = DW'(q.edge_cfg);
				A_DLY_LO: d.rdata = q.dly[DW-1:0];
				A_DLY_HI: d.rdata = DW'(q.dly[TW-1:DW]);
				A_RNG_LO: d.rdata = q.rng[DW-1:0];
				A_RNG_HI: d.rdata = DW'(q.rng[TW-1:DW]);
				A_HLD_LO: d.rdata = q.hld[DW-1:0];
				A_HLD_HI: d.rdata = DW'(q.hld[TW-1:DW]);
				A_PRE_LO: d.rdata = q.pre[DW-1:0];
				A_PRE_HI: d.rdata = DW'(q.pre[TW-1:DW]);
				A_SWP_LO: d.rdata = q.sweeps[DW-1:0];
				A_SWP_HI: d.rdata = DW'(q.sweeps[TW-1:DW]);
				A_STAT: d.rdata = DW'({q.lost, 5'h00, q.st});
				A_MON: d.rdata = DW'(q.mon_sel);
				default: d.rdata = '0; // Unmapped reads zero
			endcase
		end

		// Sweep machine
		d.timer = q.timer + TW'(1);
		case (q.st)
			S_IDLE: begin
				d.timer = '0;
				if (q.ctrl[C_ARM]) begin
					d.st = S_ARMED;
				end
			end
			S_ARMED: begin
				d.timer = '0;
				if ((start_ev || sw_start) && !blocked) begin
					d.st = S_RUN;
					d.timer = '0;
					d.sweeps = q.sweeps + TW'(1);
				end
			end
			S_RUN: begin
				// Endless runs until disarmed
				if (!q.ctrl[C_ENDLESS]
					&& (q.timer + TW'(1) >= q.rng)) begin
					d.st = S_DEAD;
					d.cnt = '0;
				end
			end
			S_DEAD: begin
				d.cnt = q.cnt + TW'(1);
				if (q.cnt >= DEAD_CYC - TW'(1)) begin
					d.cnt = '0;
					d.st = (q.hld != '0) ? S_HOLD : S_ARMED;
				end
			end
			S_HOLD: begin
				d.cnt = q.cnt + TW'(1);
				if (q.cnt >= q.hld - TW'(1)) begin
					d.st = S_ARMED;
				end
			end
			default: d.st = S_IDLE;
		endcase
		// Disarm from any state; endless keeps absolute time
		if (!q.ctrl[C_ARM]) begin
			d.st = S_IDLE;
		end
		// Status levels registered from the next state, no decode at pins
		d.armed = (d.st == S_ARMED);
		d.sweep_on = (d.st == S_RUN);

		// Forward in-window events only
		d.evt_valid = in_win && (hit != '0);
		d.evt_data = rec;
		// Extra coincident channels are dropped, set wins over clear
		if (in_win && ((hit & (hit - NCH'(1))) != '0)) begin
			d.lost = 1'b1;
		end

		// Monitor selection
		if (q.mon_sel <= M_TIME_TOP) begin
			d.mon = q.timer[q.mon_sel];
		end else if (q.mon_sel >= M_SWP_BASE && q.mon_sel <= M_SWP_TOP) begin
			d.mon = q.sweeps[q.mon_sel - M_SWP_BASE];
		end else begin
			case (q.mon_sel)
				M_ARMED: d.mon = (q.st == S_ARMED);
				M_SWEEP: d.mon = (q.st == S_RUN);
				M_WINDOW: d.mon = in_win;
				M_HOLD: d.mon = (q.st == S_HOLD);
				M_DEAD: d.mon = (q.st == S_DEAD);
				default: d.mon = 1'b0;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			q <= '0;
			q.ctrl <= CTRL_RST;
			q.chen <= CHEN_RST;
			q.edge_cfg <= EDGE_RST;
			q.st <= S_IDLE;
		end else if (CE) begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign RDATA = q.rdata;
	assign TAG_CLK = q.tag_clk;
	assign EVT_VALID = q.evt_valid;
	assign EVT_DATA = q.evt_data;
	assign MON = q.mon;
	assign ARMED = q.armed;
	assign SWEEP_ON = q.sweep_on;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST || !CE);

	property p_start;
		q.st == S_ARMED && start_ev && !blocked && q.ctrl[C_ARM]
			|=> q.st == S_RUN && q.timer == '0;
	endproperty
	a_start: assert property (p_start) else $error("start missed");

	property p_count;
		q.st == S_ARMED && d.st == S_RUN
			|=> q.sweeps == $past(q.sweeps) + TW'(1);
	endproperty
	a_count: assert property (p_count) else $error("count");

	property p_preset;
		q.st == S_ARMED && blocked |=> q.st != S_RUN;
	endproperty
	a_preset: assert property (p_preset) else $error("preset");

	property p_window;
		q.evt_valid |-> $past(in_win);
	endproperty
	a_window: assert property (p_window) else $error("window");

	property p_delay;
		q.evt_valid && !$past(q.ctrl[C_TAG])
			|-> q.evt_data[R_TIME+FW +: TW] >= $past(dly_eff);
	endproperty
	a_delay: assert property (p_delay) else $error("delay");

	property p_range;
		q.st == S_RUN && !q.ctrl[C_ENDLESS] && q.ctrl[C_ARM]
			&& q.timer + TW'(1) >= q.rng |=> q.st == S_DEAD;
	endproperty
	a_range: assert property (p_range) else $error("range");

	property p_dead;
		q.st == S_DEAD && q.cnt == DEAD_CYC - TW'(1) |=> q.st != S_DEAD;
	endproperty
	a_dead: assert property (p_dead) else $error("dead time");

	property p_hold;
		q.st == S_HOLD |=> q.st != S_RUN;
	endproperty
	a_hold: assert property (p_hold) else $error("hold-off");

	property p_tclk;
		!$past(SYS_RST) && $past(CE) |-> q.tag_clk != $past(q.tag_clk);
	endproperty
	a_tclk: assert property (p_tclk) else $error("tag clock");

	// Hold-off keeps the machine parked for its full length
	property p_hold_len;
		q.st == S_HOLD && q.ctrl[C_ARM] && q.cnt < q.hld - TW'(1)
			|=> q.st == S_HOLD;
	endproperty
	a_hold_len: assert property (p_hold_len) else $error("hold");

	// Non-zero hold-off follows the dead time
	property p_dead_hold;
		q.st == S_DEAD && q.ctrl[C_ARM] && q.cnt >= DEAD_CYC - TW'(1)
			&& q.hld != '0 |=> q.st == S_HOLD;
	endproperty
	a_dead_hold: assert property (p_dead_hold) else $error("hold");

	// Endless sweeps never time out while armed
	property p_endless;
		q.st == S_RUN && q.ctrl[C_ENDLESS] && q.ctrl[C_ARM]
			|=> q.st == S_RUN;
	endproperty
	a_endless: assert property (p_endless) else $error("endless");

	// Every record marks exactly one edge kind
	property p_edge_mark;
		q.evt_valid |-> $onehot(q.evt_data[R_EDGE +: 2]);
	endproperty
	a_edge_mark: assert property (p_edge_mark) else $error("edge");

	// Counter moves only at a start or a clear
	property p_swp_keep;
		q.st != S_ARMED |=> q.sweeps == $past(q.sweeps) || q.sweeps == '0;
	endproperty
	a_swp_keep: assert property (p_swp_keep) else $error("sweeps");

	// Tags are caught only as the tag clock rises
	property p_tag_keep;
		q.tag_clk |=> q.tag_smp == $past(q.tag_smp);
	endproperty
	a_tag_keep: assert property (p_tag_keep) else $error("tag");

	// Sweep time counts from zero at each start
	property p_zero;
		q.st == S_RUN && $past(q.st) == S_ARMED |-> q.timer == '0;
	endproperty
	a_zero: assert property (p_zero) else $error("timer");
endmodule
`default_nettype wire

// ==== test/swt_detector.sv ====
/*
 * Detector side model: start and stop pulses with fine codes, tag levels.
 * Assumes a free-running clk from the bench; all changes follow its edges.
 */
`default_nettype none
module swt_detector
	import swt_pkg::*;
(
	input wire logic clk,
	output logic start_in,
	output logic [NCH-2:0] stop_in,
	output logic [NCH*FW-1:0] fine_in,
	output logic [TAGW-1:0] tag_in
);
	timeunit 1ns;
	timeprecision 1ns;

	// Quiet lines at time zero
	initial begin
		start_in = 1'b0;
		stop_in = '0;
		fine_in = '0;
		tag_in = '0;
	end

	// One pulse of wid cycles on channel ch, fine code held throughout
	task automatic pulse(input int ch, input int wid, input logic [FW-1:0] f);
		@(posedge clk);
		fine_in[ch*FW +: FW] <= f;
		@(posedge clk);
		if (ch == 7) start_in <= 1'b1;
		else stop_in[ch] <= 1'b1;
		repeat (wid) @(posedge clk);
		if (ch == 7) start_in <= 1'b0;
		else stop_in[ch] <= 1'b0;
		@(posedge clk);
	endtask

	// Tag pattern presented on the next edge
	task automatic set_tag(input logic [TAGW-1:0] t);
		@(posedge clk);
		tag_in <= t;
	endtask
endmodule
`default_nettype wire

// ==== test/tb_swt_sweep_timing.sv ====
/*
 * Self-checking bench for the sweep timing block.
 * Assumes swt_pkg and the detector model swt_detector.
 */
`default_nettype none
module tb_swt_sweep_timing
	import swt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [AW-1:0] addr = '0;
	logic [DW-1:0] wdata = '0;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [DW-1:0] rdata;
	logic start_in, tag_clk, evt_valid, mon, armed, sweep_on;
	logic [NCH-2:0] stop_in;
	logic [NCH*FW-1:0] fine_in;
	logic [TAGW-1:0] tag_in;
	logic [RW-1:0] evt_data;
	logic [RW-1:0] evq[$];
	int failures = 0;
	int n_tests = 0;

	initial forever #25 clk = ~clk;

	swt_sweep_timing u_dut (.CLK(clk), .SYS_RST(sys_rst), .CE(1'b1),
		.ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
		.START_IN(start_in), .STOP_IN(stop_in), .FINE_IN(fine_in),
		.TAG_IN(tag_in), .TAG_CLK(tag_clk), .EVT_VALID(evt_valid),
		.EVT_DATA(evt_data), .MON(mon), .ARMED(armed), .SWEEP_ON(sweep_on));

	swt_detector u_det (.clk(clk), .start_in(start_in), .stop_in(stop_in),
		.fine_in(fine_in), .tag_in(tag_in));

	// Collect every event record
	always @(posedge clk) if (evt_valid === 1'b1) evq.push_back(evt_data);

	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	// Read data taken mid-cycle after the strobe
	task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [4:0] hdr(input int ch, input int eb);
		return {3'(ch), 2'(eb)};
	endfunction

	function automatic logic [DW-1:0] ecfg(input int ch, input int m);
		logic [2*NCH-1:0] e;
		e = EDGE_RST;
		e[2*ch +: 2] = 2'(m);
		return {16'h0, e};
	endfunction

	// Counts low-clock samples until armed (w 0) or sweep_on equals v
	task automatic wait_for(input int w, input logic v, output int n);
		n = 0;
		while (((w == 0) ? armed : sweep_on) !== v && n < 3000) begin
			@(negedge clk);
			n++;
		end
	endtask

	task automatic sweep_run(input int r, input int h);
		logic [DW-1:0] s0, s1;
		int n;
		wr(A_RNG_LO, DW'(r));
		wr(A_HLD_LO, DW'(h));
		wr(A_CTRL, 32'h1);
		wait_for(0, 1'b1, n);
		rd(A_SWP_LO, s0);
		fork
			u_det.pulse(7, 3, 5'h0);
		join_none
		wait_for(1, 1'b1, n);
		wait_for(1, 1'b0, n);
		chk(64'(n), 64'((r == 0) ? 1 : r));
		wait_for(0, 1'b1, n);
		chk(64'(n), 64'(DEAD_CYC) + 64'(h));
		rd(A_SWP_LO, s1);
		chk(s1, s0 + 1);
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		wrap_up();
	end

	initial begin
		static logic [AW-1:0] ra[5] = '{A_CTRL, A_CHEN, A_EDGE, A_STAT, 4'hf};
		static logic [DW-1:0] rv[5] = '{32'h0, 32'h7f, 32'h5555, 32'h0, 32'h0};
		logic [DW-1:0] d, v, r;
		logic [AW-1:0] a;
		logic [RW-1:0] e0;
		logic [FW-1:0] f;
		logic [TAGW-1:0] t;
		logic b;
		int c, n;
		void'($urandom(17522));
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		// Reset values, unmapped index reads zero
		for (int i = 0; i < 5; i++) begin
			rd(ra[i], d);
			chk(d, rv[i]);
		end
		// 48-bit settings, high part in low 16 bits
		for (int i = 0; i < 4; i++) begin
			a = A_DLY_LO + 4'(2 * i);
			v = $urandom() & 32'hfffffffe;
			d = $urandom();
			wr(a, v);
			wr(a + 4'h1, d);
			rd(a, r);
			chk(r, v);
			rd(a + 4'h1, r);
			chk(r, {16'h0, d[15:0]});
			wr(a + 4'h1, 32'h0);
		end
		$display("test registers done");
		sweep_run(0, 0);
		sweep_run(1, 5);
		repeat (3) sweep_run(1 + $urandom_range(29), $urandom_range(9));
		$display("test sweep timing done");
		// Window: early, two inside, one late
		evq.delete();
		c = $urandom_range(6);
		f = FW'($urandom());
		wr(A_DLY_LO, 32'd20);
		wr(A_RNG_LO, 32'd60);
		wr(A_HLD_LO, 32'h0);
		wr(A_CTRL, 32'h1);
		wait_for(0, 1'b1, n);
		fork
			u_det.pulse(7, 3, 5'h0);
		join_none
		wait_for(1, 1'b1, n);
		u_det.pulse(c, 3, f);
		repeat (20) @(posedge clk);
		u_det.pulse(c, 3, f);
		repeat (4) @(posedge clk);
		u_det.pulse(c, 3, ~f);
		repeat (20) @(posedge clk);
		u_det.pulse(c, 3, f);
		repeat (10) @(posedge clk);
		chk(64'(evq.size()), 2);
		if (evq.size() == 2) begin
			chk(evq[0][57:53], hdr(c, 1));
			chk(evq[1][4:0], {59'h0, ~f});
			chk(evq[1][52:5] - evq[0][52:5], 10);
			chk(evq[0][52:5] >= 20 && evq[0][52:5] < 60, 1);
		end
		$display("test window done");
		// Preset blocks the third start
		wr(A_PRE_LO, 32'd2);
		wr(A_RNG_LO, 32'd2);
		wr(A_CTRL, 32'h45);
		rd(A_SWP_LO, d);
		chk(d, 0);
		repeat (3) begin
			wr(A_CTRL, 32'h25);
			repeat (10) @(posedge clk);
		end
		rd(A_SWP_LO, d);
		chk(d, 2);
		wr(A_MON, {26'h0, M_SWP_BASE + 6'h1});
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk(mon, 1);
		// Endless run from a software start
		wr(A_CTRL, 32'h3);
		wr(A_CTRL, 32'h23);
		wait_for(1, 1'b1, n);
		repeat (20) @(posedge clk);
		@(negedge clk);
		chk(sweep_on, 1);
		rd(A_SWP_LO, v);
		chk(v, d + 1);
		rd(A_STAT, v);
		chk(v, 32'h2);
		wr(A_MON, 32'h0);
		repeat (2) @(posedge clk);
		@(negedge clk);
		b = mon;
		@(negedge clk);
		chk(mon, {63'h0, ~b});
		wr(A_MON, {26'h0, M_SWEEP});
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk(mon, 1);
		e0 = '0;
		for (int m = 1; m < 4; m++) begin
			wr(A_EDGE, ecfg(c, m));
			evq.delete();
			u_det.pulse(c, 3, f);
			repeat (6) @(posedge clk);
			chk(64'(evq.size()), (m == 3) ? 2 : 1);
			if (evq.size() > 0) begin
				chk(evq[0][54:53], (m == 2) ? 2 : 1);
				chk(evq[0][52:5] > e0[52:5], 1);
				e0 = evq[evq.size() - 1];
			end
			if (evq.size() == 2) chk(evq[1][52:5] - evq[0][52:5], 3);
		end
		$display("test endless done");
		// Start input as eighth channel with tags
		t = TAGW'($urandom());
		u_det.set_tag(t);
		wr(A_CHEN, 32'hff);
		wr(A_CTRL, 32'h1b);
		evq.delete();
		u_det.pulse(7, 3, f);
		repeat (6) @(posedge clk);
		chk(64'(evq.size()), 1);
		if (evq.size() == 1) begin
			chk(evq[0][57:53], hdr(7, 1));
			chk(evq[0][52:37], t);
			chk(evq[0][4:0], f);
		end
		@(negedge clk);
		b = tag_clk;
		@(negedge clk);
		chk(tag_clk, {63'h0, ~b});
		wr(A_CTRL, 32'h0);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk({armed, sweep_on}, 0);
		$display("test tags done");
		wrap_up();
	end
endmodule
`default_nettype wire
